/* File: hw/acr_host.v */
`timescale 1ns/1ps
`default_nettype none
`include "acr_defs.vh"

// Summary of operation
// - High-speed: raise strobe before EOC falls
// - Wait 30 ns after read before converting
// - Power-down: hold strobe low past 530 ns sample
// - Chip select may stay low always; here it goes low only together with read
// - EOC may drive chip select and read
// - EOC usable as edge interrupt
// - Low address bits pick channel per access
module acr_host (
    input wire clk_in,
    input wire reset_in,
    // User side
    input wire start_in,
    input wire power_down_mode_in,
    input wire [`ACR_CHAN_W-1:0] next_channel_in,
    output reg busy_out,
    output reg result_valid_out,
    output reg [`ACR_DATA_W-1:0] result_out,
    output reg timeout_out,
    // Device pins
    input wire end_of_conv_n_in,
    input wire [`ACR_DATA_W-1:0] data_in,
    output reg convert_strobe_n_out,
    output reg chip_select_n_out,
    output reg read_n_out,
    output reg channel_addr_bit2_out,
    output reg channel_addr_bit1_out,
    output reg channel_addr_bit0_out
);

// ----------------------------------------
// States
// ----------------------------------------
localparam ST_IDLE = 3'h0;
localparam ST_CONV_LOW = 3'h1;
localparam ST_WAIT_EOC = 3'h2;
localparam ST_PD_HOLD = 3'h3;
localparam ST_READ_LOW = 3'h4;
localparam ST_SETTLE = 3'h5;

// ----------------------------------------
// Registers
// ----------------------------------------
// One counter serves every timed state; cleared on entry to each timed state
reg [2:0] state;
reg [`ACR_CNT_W-1:0] count;
reg pd_mode;
reg [`ACR_CHAN_W-1:0] channel;
reg eoc_seen;
reg [`ACR_DATA_W-1:0] data_s1;
reg [`ACR_DATA_W-1:0] data_s2;
wire eoc_n_sync;

// ----------------------------------------
// Pin synchronisers
// ----------------------------------------
// End of conversion idles high, so the synchroniser resets high too
acr_sync u_eoc_sync (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .async_in(end_of_conv_n_in),
    .reset_value_in(1'b1),
    .sync_out(eoc_n_sync)
);

// ----------------------------------------
// Read data capture
// ----------------------------------------
// Data is only meaningful while read is low; sampled mid-strobe, two cycles after read falls
always @(posedge clk_in) begin
    if (reset_in) begin
        data_s1 <= {`ACR_DATA_W{1'b0}};
        data_s2 <= {`ACR_DATA_W{1'b0}};
    end else begin
        data_s1 <= data_in;
        data_s2 <= data_s1;
    end
end

// ----------------------------------------
// Helpers
// ----------------------------------------
// Strobe and read phases are short; only the low nibble takes part
function phase_done;
    input [`ACR_CNT_W-1:0] value;
    input [3:0] target;
    begin
        phase_done = (value[3:0] == target);
    end
endfunction

// Cuts a reckoned cycle count to the counter's width
function [`ACR_CNT_W-1:0] cyc;
    input [31:0] value;
    begin
        cyc = value[`ACR_CNT_W-1:0];
    end
endfunction

// ----------------------------------------
// Sequencer
// ----------------------------------------
always @(posedge clk_in) begin
    if (reset_in) begin
        state <= ST_IDLE;
        count <= {`ACR_CNT_W{1'b0}};
        pd_mode <= 1'b0;
        channel <= `ACR_CHAN_RESET;
        eoc_seen <= 1'b0;
        busy_out <= 1'b0;
        result_valid_out <= 1'b0;
        result_out <= {`ACR_DATA_W{1'b0}};
        timeout_out <= 1'b0;
        convert_strobe_n_out <= 1'b1;
        chip_select_n_out <= 1'b1;
        read_n_out <= 1'b1;
        channel_addr_bit2_out <= 1'b0;
        channel_addr_bit1_out <= 1'b0;
        channel_addr_bit0_out <= 1'b0;
    end else begin
        result_valid_out <= 1'b0;
        case (state)
        ST_IDLE: begin
            timeout_out <= 1'b0;
            // Mode and channel are frozen for the whole transfer
            if (start_in) begin
                pd_mode <= power_down_mode_in;
                channel <= next_channel_in;
                convert_strobe_n_out <= 1'b0;
                busy_out <= 1'b1;
                eoc_seen <= 1'b0;
                count <= {`ACR_CNT_W{1'b0}};
                state <= ST_CONV_LOW;
            end
        end
        ST_CONV_LOW: begin
            count <= count + 1'b1;
            if (phase_done(count, `ACR_CONV_LOW_CYC)) begin
                // High speed releases early so the device stays up
                if (!pd_mode) begin
                    convert_strobe_n_out <= 1'b1;
                end
                count <= {`ACR_CNT_W{1'b0}};
                state <= pd_mode ? ST_PD_HOLD : ST_WAIT_EOC;
            end
        end
        ST_PD_HOLD: begin
            // Strobe kept low past the device's sample point
            count <= count + 1'b1;
            if (!eoc_n_sync) begin
                eoc_seen <= 1'b1;
            end
            if (count == `ACR_PD_HOLD_CYC) begin
                count <= {`ACR_CNT_W{1'b0}};
                state <= ST_WAIT_EOC;
            end
        end
        ST_WAIT_EOC: begin
            count <= count + 1'b1;
            // A pulse seen during the hold is remembered, so a read
            // still follows once the pulse itself has ended
            if (!eoc_n_sync || eoc_seen) begin
                // Read even if powered down; pulse may be over
                chip_select_n_out <= 1'b0;
                read_n_out <= 1'b0;
                channel_addr_bit2_out <= channel[2];
                channel_addr_bit1_out <= channel[1];
                channel_addr_bit0_out <= channel[0];
                count <= {`ACR_CNT_W{1'b0}};
                state <= ST_READ_LOW;
            end else if (count == `ACR_EOC_TIMEOUT_CYC) begin
                // Abandoned conversion: a late pulse from the device
                // is ignored and its result is lost
                timeout_out <= 1'b1;
                convert_strobe_n_out <= 1'b1;
                busy_out <= 1'b0;
                state <= ST_IDLE;
            end
        end
        ST_READ_LOW: begin
            count <= count + 1'b1;
            if (phase_done(count, `ACR_READ_LOW_CYC)) begin
                result_out <= data_s2;
                result_valid_out <= 1'b1;
                read_n_out <= 1'b1;
                chip_select_n_out <= 1'b1;
                // Rising strobe wakes a powered-down device
                convert_strobe_n_out <= 1'b1;
                count <= {`ACR_CNT_W{1'b0}};
                state <= ST_SETTLE;
            end
        end
        ST_SETTLE: begin
            // Settle time runs from the rise of the read strobe
            count <= count + 1'b1;
            if (count >= cyc(`ACR_READ_SETTLE_CYC)) begin
                busy_out <= 1'b0;
                state <= ST_IDLE;
            end
        end
        default: begin
            state <= ST_IDLE;
        end
        endcase
    end
end

endmodule

`default_nettype wire

/* File: hw/acr_sync.v */
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Two-stage synchroniser, one bit
// ----------------------------------------
module acr_sync (
    input wire clk_in,
    input wire reset_in,
    input wire async_in,
    input wire reset_value_in,
    output reg sync_out
);

reg stage1;

always @(posedge clk_in) begin
    if (reset_in) begin
        stage1 <= reset_value_in;
        sync_out <= reset_value_in;
    end else begin
        stage1 <= async_in;
        sync_out <= stage1;
    end
end

endmodule

`default_nettype wire

/* File: shared/acr_defs.vh */
`ifndef ACR_DEFS_VH
`define ACR_DEFS_VH

// ----------------------------------------
// Clock and timing
// ----------------------------------------
`define ACR_CLK_PERIOD_NS 10
// Settle time after a read in high-speed mode
`define ACR_READ_SETTLE_NS 30
`define ACR_READ_SETTLE_CYC \
    ((`ACR_READ_SETTLE_NS + `ACR_CLK_PERIOD_NS - 1) / `ACR_CLK_PERIOD_NS)
// Latest strobe sample point after the convert falling edge
`define ACR_SAMPLE_MAX_NS 530
`define ACR_SAMPLE_MAX_CYC \
    ((`ACR_SAMPLE_MAX_NS + `ACR_CLK_PERIOD_NS - 1) / `ACR_CLK_PERIOD_NS)
// Longest end-of-conversion low pulse
`define ACR_EOC_MAX_NS 110
`define ACR_EOC_MAX_CYC (`ACR_EOC_MAX_NS / `ACR_CLK_PERIOD_NS)
// Strobe low width and read strobe low width (host choices)
`define ACR_CONV_LOW_CYC 4'h3
`define ACR_READ_LOW_CYC 4'h3
// Wait beyond the longest sample point, in power-down mode
`define ACR_PD_HOLD_CYC 7'h37
// Timeout waiting for end of conversion
`define ACR_EOC_TIMEOUT_CYC 7'h64

// ----------------------------------------
// Widths and reset values
// ----------------------------------------
`define ACR_DATA_W 8
`define ACR_CHAN_W 3
`define ACR_CHAN_RESET 3'h0
`define ACR_CNT_W 7

`endif

/* File: tb/acr_device_model.sv */
`timescale 1ns/1ps
`default_nettype none
module acr_device_model #(
    parameter int CONV_CYC = 30
) (
    input wire logic clk_in,
    input wire logic conv_n_in,
    input wire logic cs_n_in,
    input wire logic rd_n_in,
    input wire logic [2:0] addr_in,
    input wire logic mute_in,
    output logic eoc_n_out = 1'b1,
    output logic pd_out = 1'b0,
    output logic [7:0] data_out
);
    logic conv_d = 1'b1, rd_d = 1'b1, busy = 1'b0;
    logic [2:0] chan = 3'h0;
    logic [7:0] result = 8'h00, last = 8'h00;
    logic [4:0] num = 5'h00;
    int cnt = 0, low = 0;
    always @(posedge clk_in) begin
        conv_d <= conv_n_in;
        rd_d <= rd_n_in;
        if (!cs_n_in && rd_d && !rd_n_in)
            chan <= addr_in;
        if (!conv_n_in && conv_d) begin
            busy <= 1'b1;
            cnt <= 0;
        end else if (busy)
            cnt <= cnt + 1;
        if (busy && cnt == CONV_CYC && !mute_in) begin
            busy <= 1'b0;
            result <= {num, chan};
            num <= num + 5'h01;
            eoc_n_out <= 1'b0;
            low <= 0;
        end
        if (!eoc_n_out) begin
            low <= low + 1;
            if (low == 9 || (!rd_d && rd_n_in)) begin
                eoc_n_out <= 1'b1;
                pd_out <= !conv_n_in;
            end
        end
        if (conv_n_in && !conv_d)
            pd_out <= 1'b0;
        if (!cs_n_in && !rd_n_in)
            last <= result;
    end
    // Released bus shows inverted value, never a stale copy
    assign data_out = (!cs_n_in && !rd_n_in) ?
        result : ~last;
endmodule
`default_nettype wire

/* File: tb/acr_host_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module acr_host_checker (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic start_in,
    input wire logic power_down_mode_in,
    input wire logic busy_out,
    input wire logic end_of_conv_n_in,
    input wire logic convert_strobe_n_out,
    input wire logic chip_select_n_out,
    input wire logic read_n_out,
    input wire logic channel_addr_bit2_out,
    input wire logic channel_addr_bit1_out,
    input wire logic channel_addr_bit0_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (reset_in);
    // Mode is only taken with an accepted start
    logic pd = 1'b0;
    always @(posedge clk_in)
        if (start_in && !busy_out)
            pd <= power_down_mode_in;
    fast_release_a: assert property (
        !pd && $fell(convert_strobe_n_out) |-> ##4 $rose(convert_strobe_n_out))
        else $error("strobe not raised early");
    settle_gap_a: assert property (
        $rose(read_n_out) |-> (!$fell(convert_strobe_n_out)) [*3])
        else $error("convert too soon after read");
    pd_hold_a: assert property (
        pd && $rose(end_of_conv_n_in) |-> !convert_strobe_n_out)
        else $error("strobe high at sample point");
    pair_select_a: assert property (
        $fell(read_n_out) |-> !chip_select_n_out)
        else $error("read without select");
    read_width_a: assert property (
        $fell(read_n_out) |-> (!read_n_out) [*4] ##1 read_n_out)
        else $error("read width wrong");
    read_follow_a: assert property (
        $fell(end_of_conv_n_in) && busy_out |-> ##[1:70] $fell(read_n_out))
        else $error("no read after end of conversion");
    addr_hold_a: assert property (
        !read_n_out && !$fell(read_n_out) |-> $stable({channel_addr_bit2_out,
        channel_addr_bit1_out, channel_addr_bit0_out}))
        else $error("address moved during read");
endmodule
`default_nettype wire

/* File: tb/acr_host_test.sv */
`timescale 1ns/1ps
`default_nettype none
module acr_host_test;
    logic clk_in = 1'b0, reset_in = 1'b1, start = 1'b0, mode = 1'b0;
    logic mute = 1'b0;
    logic [2:0] chan = 3'h0, prev = 3'h0;
    logic busy, valid, tmo, eoc_n, conv_n, cs_n, rd_n, a2, a1, a0, pd;
    logic pd_seen = 1'b0;
    logic [7:0] result, data;
    logic [4:0] num = 5'h00;
    int bad_count = 0, check_count = 0, cycles = 0;
    always #5 clk_in = ~clk_in;
    acr_host i_dut (.clk_in(clk_in), .reset_in(reset_in), .start_in(start),
        .power_down_mode_in(mode), .next_channel_in(chan), .busy_out(busy),
        .result_valid_out(valid), .result_out(result), .timeout_out(tmo),
        .end_of_conv_n_in(eoc_n), .data_in(data),
        .convert_strobe_n_out(conv_n), .chip_select_n_out(cs_n),
        .read_n_out(rd_n), .channel_addr_bit2_out(a2),
        .channel_addr_bit1_out(a1), .channel_addr_bit0_out(a0));
    acr_device_model i_dev (.clk_in(clk_in), .conv_n_in(conv_n),
        .cs_n_in(cs_n), .rd_n_in(rd_n), .addr_in({a2, a1, a0}),
        .mute_in(mute), .eoc_n_out(eoc_n), .pd_out(pd), .data_out(data));
    always @(posedge clk_in) begin
        pd_seen <= start ? 1'b0 : (pd_seen | pd);
        cycles++;
        if (cycles == 5000) begin
            bad_count++;
            finish_test();
        end
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        if (bad_count == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic no_answer();
        @(negedge clk_in);
        start = 1'b1;
        mode = 1'b0;
        mute = 1'b1;
        @(negedge clk_in);
        start = 1'b0;
        for (int i = 0; i < 200 && tmo !== 1'b1; i++) @(negedge clk_in);
        check({4'h0, valid, rd_n, busy, tmo}, 8'h05);
        mute = 1'b0;
        @(negedge clk_in);
    endtask
    task automatic convert(input logic m, input logic [2:0] c);
        @(negedge clk_in);
        start = 1'b1;
        mode = m;
        chan = c;
        @(negedge clk_in);
        start = 1'b0;
        for (int i = 0; i < 300 && valid !== 1'b1; i++) @(negedge clk_in);
        check(result, {num, prev});
        check({7'h00, pd_seen}, {7'h00, m});
        num++;
        prev = c;
        for (int i = 0; i < 50 && busy !== 1'b0; i++) @(negedge clk_in);
        check({6'h00, pd, tmo}, 8'h00);
    endtask
    initial begin
        repeat (3) @(negedge clk_in);
        reset_in = 1'b0;
        check({busy, conv_n, rd_n, cs_n, a2, a1, a0, valid}, 8'h70);
        for (int i = 0; i < 8; i++) convert(1'b0, 3'(7 - i));
        no_answer();
        convert(1'b1, 3'h5);
        convert(1'b1, 3'h2);
        convert(1'b0, 3'h0);
        finish_test();
    end
endmodule
bind acr_host acr_host_checker i_chk (.clk_in(clk_in), .reset_in(reset_in),
    .start_in(start_in), .power_down_mode_in(power_down_mode_in),
    .busy_out(busy_out), .end_of_conv_n_in(end_of_conv_n_in),
    .convert_strobe_n_out(convert_strobe_n_out),
    .chip_select_n_out(chip_select_n_out), .read_n_out(read_n_out),
    .channel_addr_bit2_out(channel_addr_bit2_out),
    .channel_addr_bit1_out(channel_addr_bit1_out),
    .channel_addr_bit0_out(channel_addr_bit0_out));
`default_nettype wire
